/* File: hw/uart_line_status_modem_ctrl.sv */
// Operation
// - Bit 7 set while any FIFO entry errored
// - Bit 6 means holding and shift empty
// - Bit 5 means transmit holding stage empty
// - Break flagged in bit 4, stores 00
// - Bit 3 is head character stop error
// - Bit 2 is head character parity error
// - Bit 1 shows receive overrun occurred
// - Bit 0 means receive FIFO holds data
// - Bits 4:2 come from head tags while data is ready
// - Status read never moves read pointer
// - Control bit 7 selects divide 1/4
// - Control bit 6 opens threshold registers
// - Control bit 5 enables resume-on-any
// - Control bits 7:5 need write enable
module uart_line_status_modem_ctrl
   import uart_lsmc_pkg::*;
#(
   parameter int DEPTH = RX_DEPTH
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Host register strobes
   input wire logic RD_STATUS,
   input wire logic RD_RX,
   input wire logic RD_MC,
   input wire logic WR_MC,
   input wire logic [7:0] WR_DATA,
   input wire logic [7:0] ENH_FEATURE,
   // Host read data
   output logic [7:0] DOUT,
   // Receiver side, same clock
   input wire logic RX_PUSH,
   input wire logic [7:0] RX_CHAR,
   input wire logic RX_BRK,
   input wire logic RX_STOP_ERR,
   input wire logic RX_PAR_ERR,
   // Transmitter state, same clock
   input wire logic TX_HOLD_EMPTY,
   input wire logic TX_SHIFT_EMPTY,
   // Control outputs
   output logic BAUD_TICK,
   output logic CLK_DIV4,
   output logic FLOW_REG_ACCESS,
   output logic XON_ANY
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
   localparam logic [AW:0] ONE = (AW + 1)'(1);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   host_rd_t rd; // Grouped read strobes
   rx_entry_t mem [DEPTH]; // Receive FIFO storage
   rx_entry_t head; // Entry at the read pointer
   rx_entry_t in_entry; // Entry about to be written
   logic [AW-1:0] wptr, next_wptr; // Write index
   logic [AW-1:0] rptr, next_rptr; // Read index
   logic [AW:0] count, next_count; // Characters held
   logic [AW:0] err_cnt, next_err_cnt; // Entries carrying an error
   logic overrun, next_overrun; // Sticky overrun flag
   logic push_ok, pop_ok; // Accepted FIFO moves
   logic in_err, head_err; // Error summary of in and head
   logic [2:0] mc, next_mc; // Upper modem control bits
   logic [1:0] pre_cnt, next_pre_cnt; // Prescaler count
   logic next_tick; // Prescaler tick
   logic [7:0] status; // Live line status word
   logic [7:0] next_dout; // Read data
   logic clk_sel; // Divide-by-four selected

   assign rd = '{rd_status: RD_STATUS, rd_rx: RD_RX, rd_mc: RD_MC};
   assign head = mem[rptr];
   assign clk_sel = mc[MC_CLK_DIV4 - 5];

   // Break replaces the character by a zero byte
   always_comb begin
      in_entry.brk = RX_BRK;
      in_entry.stop_err = RX_STOP_ERR;
      in_entry.par_err = RX_PAR_ERR;
      in_entry.data = RX_BRK ? BREAK_CHAR : RX_CHAR;
      in_err = RX_BRK | RX_STOP_ERR | RX_PAR_ERR;
      head_err = head.brk | head.stop_err | head.par_err;
   end

   // FIFO next state; only the holding register read pops
   always_comb begin
      pop_ok = rd.rd_rx && (count != '0);
      // A full FIFO still takes a char when a pop frees room
      push_ok = RX_PUSH && ((count != FULL_COUNT) || pop_ok);
      next_wptr = wptr;
      next_rptr = rptr;
      next_count = count;
      next_err_cnt = err_cnt;
      next_overrun = overrun;
      if (push_ok) begin
         next_wptr = (wptr == LAST_IDX) ? '0 : wptr + AW'(1);
      end
      if (pop_ok) begin
         next_rptr = (rptr == LAST_IDX) ? '0 : rptr + AW'(1);
      end
      if (push_ok && !pop_ok) begin
         next_count = count + ONE;
      end else if (pop_ok && !push_ok) begin
         next_count = count - ONE;
      end
      // Count errored entries so bit 7 clears only when none remain
      if ((push_ok && in_err) && !(pop_ok && head_err)) begin
         next_err_cnt = err_cnt + ONE;
      end else if (!(push_ok && in_err) && (pop_ok && head_err)) begin
         next_err_cnt = err_cnt - ONE;
      end
      // Status read clears overrun; a new overrun wins the same cycle
      if (rd.rd_status) begin
         next_overrun = 1'b0;
      end
      if (RX_PUSH && !push_ok) begin
         next_overrun = 1'b1;
      end
   end

   // FIFO registers; storage itself needs no reset
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         err_cnt <= '0;
         overrun <= 1'b0;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         err_cnt <= next_err_cnt;
         overrun <= next_overrun;
      end
   end

   // Storage write
   always_ff @(posedge CLK) begin
      if (push_ok) begin
         mem[wptr] <= in_entry;
      end
   end

   // Line status word; tags are wired from the head, never stored
   always_comb begin
      status = '0;
      status[LS_FIFO_ERR] = (err_cnt != '0);
      status[LS_TX_EMPTY] = TX_HOLD_EMPTY && TX_SHIFT_EMPTY;
      status[LS_HOLD_EMPTY] = TX_HOLD_EMPTY;
      if (count != '0) begin
         status[LS_BREAK] = head.brk;
         status[LS_STOP_ERR] = head.stop_err;
         status[LS_PARITY] = head.par_err;
      end
      status[LS_OVERRUN] = overrun;
      status[LS_DATA_READY] = (count != '0);
   end

   // Modem control: upper bits change only under the write enable
   always_comb begin
      next_mc = mc;
      if (WR_MC && ENH_FEATURE[EF_WRITE_EN]) begin
         next_mc = WR_DATA[7:5];
      end
   end

   // Prescaler: tick every cycle, or every fourth when selected
   always_comb begin
      next_pre_cnt = pre_cnt + 2'h1;
      next_tick = clk_sel ? (pre_cnt == DIV4_LAST) : 1'b1;
   end

   // Read data mux; status beats holding, holding beats control
   always_comb begin
      next_dout = DOUT;
      if (rd.rd_status) begin
         next_dout = status;
      end else if (rd.rd_rx) begin
         // Reading an empty FIFO returns the stale head byte
         next_dout = head.data;
      end else if (rd.rd_mc) begin
         next_dout = {mc, 5'h00};
      end
   end

   // Control and read data registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mc <= MC_RESET;
         pre_cnt <= '0;
         BAUD_TICK <= 1'b0;
         DOUT <= LS_RESET;
         CLK_DIV4 <= 1'b0;
         FLOW_REG_ACCESS <= 1'b0;
         XON_ANY <= 1'b0;
      end else begin
         mc <= next_mc;
         pre_cnt <= next_pre_cnt;
         BAUD_TICK <= next_tick;
         DOUT <= next_dout;
         CLK_DIV4 <= next_mc[MC_CLK_DIV4 - 5];
         FLOW_REG_ACCESS <= next_mc[MC_FLOW_ACCESS - 5];
         XON_ANY <= next_mc[MC_XON_ANY - 5];
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   a_fifo_err_flag: assert property (
      RD_STATUS |=> DOUT[7] == $past(err_cnt != '0))
      else $error("fifo error flag wrong");
   a_tx_empty_bit: assert property (
      RD_STATUS |=> DOUT[6] == $past(TX_HOLD_EMPTY && TX_SHIFT_EMPTY))
      else $error("transmit empty bit wrong");
   a_hold_empty_bit: assert property (
      RD_STATUS |=> DOUT[5] == $past(TX_HOLD_EMPTY))
      else $error("holding empty bit wrong");
   a_break_zero_byte: assert property (
      push_ok && RX_BRK |=> mem[$past(wptr)].data == BREAK_CHAR)
      else $error("break char not zero");
   a_head_tags_out: assert property (
      RD_STATUS && count != '0 |=>
      DOUT[4:2] == $past({head.brk, head.stop_err, head.par_err}))
      else $error("head tags not on status");
   a_overrun_sets: assert property (
      RX_PUSH && count == FULL_COUNT && !RD_RX |=>
      overrun && count == FULL_COUNT)
      else $error("overrun not flagged");
   a_data_ready_bit: assert property (
      RD_STATUS |=> DOUT[0] == $past(count != '0))
      else $error("data ready bit wrong");
   a_status_no_pop: assert property (
      RD_STATUS && !RD_RX |=> rptr == $past(rptr))
      else $error("status read moved pointer");
   a_div4_spacing: assert property (
      $past(clk_sel) && clk_sel && BAUD_TICK |=> !BAUD_TICK)
      else $error("divide by four tick too soon");
   a_div1_every: assert property (
      !clk_sel |=> BAUD_TICK)
      else $error("divide by one missed tick");
   a_mc_locked: assert property (
      WR_MC && !ENH_FEATURE[EF_WRITE_EN] |=> mc == $past(mc))
      else $error("locked control bits changed");
   a_mc_written: assert property (
      WR_MC && ENH_FEATURE[EF_WRITE_EN] |=>
      FLOW_REG_ACCESS == $past(WR_DATA[6]))
      else $error("flow access bit not written");

   c_fifo_full: cover property (count == FULL_COUNT);
   c_overrun_read: cover property (overrun ##1 RD_STATUS);
   c_error_drain: cover property (err_cnt == ONE ##[1:50] err_cnt == '0);
   c_div4_run: cover property (clk_sel && BAUD_TICK ##4 BAUD_TICK);
endmodule

/* File: hw/uart_lsmc_pkg.sv */
package uart_lsmc_pkg;
   // Line status bit positions
   localparam int LS_FIFO_ERR = 7;
   localparam int LS_TX_EMPTY = 6;
   localparam int LS_HOLD_EMPTY = 5;
   localparam int LS_BREAK = 4;
   localparam int LS_STOP_ERR = 3;
   localparam int LS_PARITY = 2;
   localparam int LS_OVERRUN = 1;
   localparam int LS_DATA_READY = 0;
   // Modem control bit positions (only the upper three are kept here)
   localparam int MC_CLK_DIV4 = 7;
   localparam int MC_FLOW_ACCESS = 6;
   localparam int MC_XON_ANY = 5;
   // Write enable bit of the enhanced feature register
   localparam int EF_WRITE_EN = 4;
   // Values after reset, and the byte stored for a break
   localparam logic [7:0] LS_RESET = 8'h60;
   localparam logic [2:0] MC_RESET = 3'h0;
   localparam logic [7:0] BREAK_CHAR = 8'h00;
   // Prescaler: divide by four means one tick on the last of four counts
   localparam logic [1:0] DIV4_LAST = 2'h3;
   // Default receive FIFO depth
   localparam int RX_DEPTH = 64;

   // One receive FIFO entry: character plus its error tags
   typedef struct packed {
      logic brk;
      logic stop_err;
      logic par_err;
      logic [7:0] data;
   } rx_entry_t;

   // Host read strobe group
   typedef struct packed {
      logic rd_status;
      logic rd_rx;
      logic rd_mc;
   } host_rd_t;
endpackage

/* File: bench/host_model.sv */
// Host processor on the parallel register bus
module host_model
   import uart_lsmc_pkg::*;
(
   // Clock and returned data
   input wire logic CLK,
   input wire logic [7:0] DOUT,
   // Strobes toward the device
   output host_rd_t RD,
   output logic WR_MC,
   output logic [7:0] WR_DATA
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      RD = '0;
      WR_MC = 1'b0;
      WR_DATA = 8'hA5;
   end

   // One read: strobe over one edge, data taken once that edge lands
   task automatic rd(input host_rd_t sel, output logic [7:0] d);
      @(posedge CLK);
      #1 RD = sel;
      @(posedge CLK);
      #1 RD = '0;
      d = DOUT;
   endtask

   // One write; released data lines do not keep the old value
   task automatic wr(input logic [7:0] v);
      @(posedge CLK);
      #1 WR_MC = 1'b1;
      WR_DATA = v;
      @(posedge CLK);
      #1 WR_MC = 1'b0;
      WR_DATA = ~v;
   endtask

   // Status first, then the character it describes
   task automatic rd_char(output logic [7:0] st, output logic [7:0] ch);
      rd('{1'b1, 1'b0, 1'b0}, st);
      rd('{1'b0, 1'b1, 1'b0}, ch);
   endtask
endmodule

/* File: bench/test_uart_line_status_modem_ctrl.sv */
module test_uart_line_status_modem_ctrl
   import uart_lsmc_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   // Bench signals
   logic clk = 1'b0, sys_rst = 1'b1, wr_mc, rx_push = 1'b0;
   logic rx_brk = 1'b0, rx_stop_err = 1'b0, rx_par_err = 1'b0;
   logic tx_hold_empty = 1'b1, tx_shift_empty = 1'b1;
   // Control pins packed the way the register reads back
   logic [7:0] pins;
   logic baud_tick, clk_div4, flow_reg_access, xon_any;
   logic [7:0] wr_data, dout, enh_feature = 8'h00, rx_char = 8'h00, st, ch;
   host_rd_t rd;
   int n_fail = 0, total_checks = 0;

   // 50 ns clock
   always #25 clk = ~clk;

   host_model host (.CLK(clk), .DOUT(dout), .RD(rd), .WR_MC(wr_mc),
      .WR_DATA(wr_data));
   // Small FIFO so overrun is cheap to reach
   uart_line_status_modem_ctrl #(.DEPTH(4)) uut (.CLK(clk),
      .SYS_RST(sys_rst), .RD_STATUS(rd.rd_status), .RD_RX(rd.rd_rx),
      .RD_MC(rd.rd_mc), .WR_MC(wr_mc), .WR_DATA(wr_data),
      .ENH_FEATURE(enh_feature), .DOUT(dout), .RX_PUSH(rx_push),
      .RX_CHAR(rx_char), .RX_BRK(rx_brk), .RX_STOP_ERR(rx_stop_err),
      .RX_PAR_ERR(rx_par_err), .TX_HOLD_EMPTY(tx_hold_empty),
      .TX_SHIFT_EMPTY(tx_shift_empty), .BAUD_TICK(baud_tick),
      .CLK_DIV4(clk_div4), .FLOW_REG_ACCESS(flow_reg_access),
      .XON_ANY(xon_any));
   assign pins = {clk_div4, flow_reg_access, xon_any, 5'h00};

   // Compare and count
   task automatic chk(input string what, input logic [7:0] e,
         input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   // Receiver hands over one character with tags {brk, stop, parity}
   task automatic push(input logic [7:0] c, input logic [2:0] t);
      @(posedge clk);
      #1 rx_push = 1'b1;
      rx_char = c;
      {rx_brk, rx_stop_err, rx_par_err} = t;
      @(posedge clk);
      #1 rx_push = 1'b0;
      rx_char = ~c;
   endtask

   // Values right after reset
   task automatic t_reset();
      // Read data and control pins straight out of reset
      chk("reset dout", LS_RESET, dout);
      chk("reset pins", 8'h00, pins);
      host.rd('{1'b1, 1'b0, 1'b0}, st);
      chk("reset status", LS_RESET, st);
      host.rd('{1'b0, 1'b0, 1'b1}, st);
      chk("reset control", 8'h00, st);
   endtask

   // Every transmitter empty combination
   task automatic t_tx();
      for (int i = 0; i < 4; i++) begin
         {tx_hold_empty, tx_shift_empty} = 2'(i);
         host.rd('{1'b1, 1'b0, 1'b0}, st);
         chk("tx status", {1'b0, i == 3, i > 1, 5'h00}, st);
      end
      {tx_hold_empty, tx_shift_empty} = 2'h3;
   endtask

   // Clean head with errored entries behind it, then each error kind
   task automatic t_tags();
      logic [2:0] tg [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
      for (int i = 0; i < 4; i++) push(8'h3C + 8'(i), tg[i]);
      for (int i = 0; i < 4; i++) begin
         // Status read must not move the head
         host.rd('{1'b1, 1'b0, 1'b0}, st);
         host.rd_char(st, ch);
         chk("rx status", 8'hE1 | {3'h0, tg[i], 2'h0}, st);
         chk("rx char", tg[i][2] ? BREAK_CHAR : 8'h3C + 8'(i), ch);
      end
      host.rd('{1'b1, 1'b0, 1'b0}, st);
      chk("drained status", 8'h60, st);
   endtask

   // One push too many into the four-entry FIFO
   task automatic t_overrun();
      for (int i = 0; i < 5; i++) push(8'(i + 1), 3'h0);
      host.rd('{1'b1, 1'b0, 1'b0}, st);
      chk("overrun status", 8'h63, st);
      host.rd('{1'b1, 1'b0, 1'b0}, st);
      chk("overrun cleared", 8'h61, st);
      for (int i = 0; i < 4; i++) host.rd_char(st, ch);
      chk("last kept char", 8'h04, ch);
   endtask

   // Upper control bits, write enable and prescaler
   task automatic t_ctrl();
      logic [15:0] tb [5] = '{16'h0E00, 16'h1A0, 16'h140, 16'h000, 16'h1E0};
      logic [7:0] e, n;
      for (int i = 0; i < 5; i++) begin
         enh_feature = {3'h0, tb[i][8], 4'h0};
         host.wr(tb[i][7:0] | tb[i][11:4]);
         e = tb[i][8] ? tb[i][7:0] : e;
         if (i == 0) e = 8'h00;
         host.rd('{1'b0, 1'b0, 1'b1}, st);
         chk("control", e, st);
         chk("control pins", e, pins);
         n = 8'h00;
         repeat (8) begin
            @(posedge clk);
            #1 n = n + 8'(baud_tick);
         end
         chk("ticks", e[7] ? 8'h02 : 8'h08, n);
      end
   endtask

   // Reset in mid-run drops a stored break char and the control bits
   task automatic t_rerun();
      push(8'h55, 3'h4);
      @(posedge clk);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 sys_rst = 1'b0;
      // Same values as after the first reset
      t_reset();
   endtask

   // Report and stop
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Guard against a hang
   initial begin
      #200000;
      n_fail++;
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      #1 sys_rst = 0;
      t_reset();
      t_tx();
      t_tags();
      t_overrun();
      t_ctrl();
      t_rerun();
      end_of_test();
   end
endmodule
